// >>> verilog/sbrg_pkg.sv
// Purpose: Shared constants and types for the serial bit-rate generator.
// Assumes: One 20 MHz system clock; registers reached over AXI4-Lite.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package sbrg_pkg;

  // System clock rate in hertz; the generator divides this clock.
  localparam int unsigned CLK_HZ = 20_000_000;

  // AXI4-Lite address width used by the register slave.
  localparam int unsigned AXI_AW = 8;

  // Register byte offsets.
  localparam logic [7:0] OFF_TXSC   = 8'h00; // Transmit status and control.
  localparam logic [7:0] OFF_RXSC   = 8'h04; // Receive status and control.
  localparam logic [7:0] OFF_RATE   = 8'h08; // Rate control.
  localparam logic [7:0] OFF_DIV_HI = 8'h0C; // Divisor high byte.
  localparam logic [7:0] OFF_DIV_LO = 8'h10; // Divisor low byte.
  localparam logic [7:0] OFF_STATUS = 8'h14; // Generator status.

  // Values after reset of the stored bytes.
  localparam logic [7:0] RST_TXSC = 8'h00;
  localparam logic [7:0] RST_RXSC = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h00;
  localparam logic [7:0] RST_DIV  = 8'h00;

  // Writable bits of each control byte, and read-only bits reading one.
  localparam logic [7:0] TXSC_WMASK = 8'hFD;
  localparam logic [7:0] TXSC_ONES  = 8'h02;
  localparam logic [7:0] RXSC_WMASK = 8'hF8;
  localparam logic [7:0] RATE_WMASK = 8'hBB;
  localparam logic [7:0] RATE_ONES  = 8'h40;

  // Field positions.
  localparam int unsigned BIT_CLK_SRC   = 7; // Transmit byte: clock source select.
  localparam int unsigned BIT_SYNC      = 4; // Transmit byte: synchronous mode.
  localparam int unsigned BIT_HIGH_SPD  = 2; // Transmit byte: high speed select.
  localparam int unsigned BIT_SIXTEEN   = 3; // Rate byte: sixteen-bit select.
  localparam int unsigned BIT_ST_RXLVL  = 0; // Status: voted receive level.
  localparam int unsigned BIT_ST_MASTER = 1; // Status: internal clock in synchronous mode.
  localparam int unsigned BIT_ST_COUNT  = 16; // Status: timer count, low bit.

  // Prescaler terminal counts: device clock divided by 64, 16 or 4.
  localparam logic [5:0] PRE_LAST_64 = 6'h3F;
  localparam logic [5:0] PRE_LAST_16 = 6'h0F;
  localparam logic [5:0] PRE_LAST_4  = 6'h03;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Decoded mode bits that steer the generator.
  typedef struct packed {
    logic syncMode;
    logic clockSource;
    logic highSpeed;
    logic sixteenBit;
  } sbrg_cfg_t;

endpackage

// >>> verilog/sbrg_majority_sampler.sv
// Purpose: Majority-of-three vote on the receive data pin.
// Assumes: The pin level arrives already synchronised to sys_clk.
// Notes:   The vote is taken once per bit, at the bit-timing strobe.
`timescale 1ns/1ps
module sbrg_majority_sampler (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic pinLevel,
  input  wire logic voteEn,
  output logic      votedLevel
);

  ////////////////////////////////////////////////////////////////////
  // Sample history.
  ////////////////////////////////////////////////////////////////////

  logic [2:0] sample_reg; // Last three pin samples, newest in bit 0.
  logic       vote_next;  // Majority of the three samples.

  // Each cycle shifts in one sample, so the vote sees the three
  // samples taken just before the strobe.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sample_reg <= 3'h7;
    end else begin
      sample_reg <= {sample_reg[1:0], pinLevel};
    end
  end

  // Two of three decide, so a single glitch cannot flip the level.
  always_comb begin
    vote_next = (sample_reg[0] & sample_reg[1]) |
                (sample_reg[0] & sample_reg[2]) |
                (sample_reg[1] & sample_reg[2]);
  end

  ////////////////////////////////////////////////////////////////////
  // Voted output.
  ////////////////////////////////////////////////////////////////////

  // The line idles high, so the vote resets to one.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      votedLevel <= 1'b1;
    end else if (voteEn) begin
      votedLevel <= vote_next;
    end
  end

endmodule // sbrg_majority_sampler

// >>> verilog/sbrg_rate_gen.sv
// Purpose: Serial bit-rate generator with AXI4-Lite control registers.
// Assumes: One clock, sys_clk at 20 MHz; synchronous active-high reset.
// Notes:   bitTick paces the transmitter and receiver for one cycle.
//
// Notes on behaviour
// - Eight-bit counter by default, sixteen-bit when selected.
// - Divisor bytes set free-running timer reload period.
// - High speed matters only in asynchronous mode.
// - Divide by 64, 16 or 4 times n+1.
// - Divisor is high byte over low byte.
// - Rate formulas apply only to internal master clock.
// - Divisor write clears the timer immediately.
// - Receive pin voted by majority of three.
// - Eight-bit mode ignores the high byte.
// - Synchronous clock source picks master or slave.
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module sbrg_rate_gen (
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  // AXI4-Lite write address channel.
  input  wire logic [sbrg_pkg::AXI_AW-1:0]   awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  // AXI4-Lite write data channel.
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  // AXI4-Lite write response channel.
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  // AXI4-Lite read address channel.
  input  wire logic [sbrg_pkg::AXI_AW-1:0]   araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  // AXI4-Lite read data channel.
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  // Serial pins, both asynchronous to sys_clk.
  input  wire logic                          receiveDataPin,
  input  wire logic                          extClockPin,
  // Timing and data towards the transmitter and receiver.
  output logic                               bitTick,
  output logic                               rxLevel,
  output logic                               masterClockActive
);

  ////////////////////////////////////////////////////////////////////
  // Register storage.
  ////////////////////////////////////////////////////////////////////

  logic [7:0]           txsc_reg;   // Transmit status and control.
  logic [7:0]           rxsc_reg;   // Receive status and control.
  logic [7:0]           rate_reg;   // Rate control.
  logic [7:0]           divHi_reg;  // Divisor high byte.
  logic [7:0]           divLo_reg;  // Divisor low byte.
  sbrg_pkg::sbrg_cfg_t  cfg;        // Decoded mode bits.

  ////////////////////////////////////////////////////////////////////
  // AXI write path state.
  ////////////////////////////////////////////////////////////////////

  logic                        awHeld_reg; // Write address captured.
  logic [sbrg_pkg::AXI_AW-1:0] awAddr_reg; // Captured write address.
  logic                        wHeld_reg;  // Write data captured.
  logic [7:0]                  wByte_reg;  // Captured byte lane zero.
  logic                        wLane0_reg; // Byte lane zero strobed.
  logic                        wrFire;     // Both halves present.
  logic [7:0]                  wrOff;      // Word-aligned write offset.
  logic                        divWrite;   // Write hits a divisor byte.

  // Each channel is ready while its own half is not yet held and no
  // response is waiting, so address and data may come in either order.
  always_comb begin
    awready = !awHeld_reg && !bvalid;
    wready  = !wHeld_reg && !bvalid;
    arready = !rvalid;
  end

  // The write is carried out one cycle after the later half arrived.
  always_comb begin
    wrFire   = awHeld_reg && wHeld_reg && !bvalid;
    wrOff    = {awAddr_reg[7:2], 2'h0};
    divWrite = wrFire && wLane0_reg &&
               (wrOff == sbrg_pkg::OFF_DIV_HI || wrOff == sbrg_pkg::OFF_DIV_LO);
  end

  // Capture of the write address half.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= '0;
    end else if (awvalid && awready) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= awaddr;
    end else if (wrFire) begin
      awHeld_reg <= 1'b0;
    end
  end

  // Capture of the write data half; only lane zero carries bits.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wHeld_reg  <= 1'b0;
      wByte_reg  <= 8'h00;
      wLane0_reg <= 1'b0;
    end else if (wvalid && wready) begin
      wHeld_reg  <= 1'b1;
      wByte_reg  <= wdata[7:0];
      wLane0_reg <= wstrb[0];
    end else if (wrFire) begin
      wHeld_reg <= 1'b0;
    end
  end

  // Write response; the status word is read-only and answers an error
  // on write just like an unmapped offset.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bvalid <= 1'b0;
      bresp  <= sbrg_pkg::RESP_OKAY;
    end else if (wrFire) begin
      bvalid <= 1'b1;
      unique case (wrOff)
        sbrg_pkg::OFF_TXSC, sbrg_pkg::OFF_RXSC, sbrg_pkg::OFF_RATE,
        sbrg_pkg::OFF_DIV_HI, sbrg_pkg::OFF_DIV_LO: begin
          bresp <= sbrg_pkg::RESP_OKAY;
        end
        default: begin
          bresp <= sbrg_pkg::RESP_SLVERR;
        end
      endcase
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Control and divisor registers.
  ////////////////////////////////////////////////////////////////////

  // Control bytes keep only their writable bits; a write without lane
  // zero strobed changes nothing.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      txsc_reg <= sbrg_pkg::RST_TXSC;
      rxsc_reg <= sbrg_pkg::RST_RXSC;
      rate_reg <= sbrg_pkg::RST_RATE;
    end else if (wrFire && wLane0_reg) begin
      if (wrOff == sbrg_pkg::OFF_TXSC) begin
        txsc_reg <= wByte_reg & sbrg_pkg::TXSC_WMASK;
      end
      if (wrOff == sbrg_pkg::OFF_RXSC) begin
        rxsc_reg <= wByte_reg & sbrg_pkg::RXSC_WMASK;
      end
      if (wrOff == sbrg_pkg::OFF_RATE) begin
        rate_reg <= wByte_reg & sbrg_pkg::RATE_WMASK;
      end
    end
  end

  // Divisor bytes; the reset value selects the fastest rate.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      divHi_reg <= sbrg_pkg::RST_DIV;
      divLo_reg <= sbrg_pkg::RST_DIV;
    end else if (divWrite) begin
      if (wrOff == sbrg_pkg::OFF_DIV_HI) begin
        divHi_reg <= wByte_reg;
      end else begin
        divLo_reg <= wByte_reg;
      end
    end
  end

  // Mode bits pulled out of the control bytes.
  always_comb begin
    cfg.syncMode    = txsc_reg[sbrg_pkg::BIT_SYNC];
    cfg.clockSource = txsc_reg[sbrg_pkg::BIT_CLK_SRC];
    cfg.highSpeed   = txsc_reg[sbrg_pkg::BIT_HIGH_SPD];
    cfg.sixteenBit  = rate_reg[sbrg_pkg::BIT_SIXTEEN];
  end

  ////////////////////////////////////////////////////////////////////
  // Rate timer.
  ////////////////////////////////////////////////////////////////////

  logic [5:0]  pre_reg;   // Prescaler count of device clocks.
  logic [5:0]  preLast;   // Prescaler terminal count for this mode.
  logic        preTick;   // Prescaler wraps this cycle.
  logic [15:0] count_reg; // Free-running timer count.
  logic [15:0] divisor;   // End count n in use; the timer reloads zero.
  logic        rateTick;  // Timer period ends this cycle.

  // Prescaler ratio from mode bits. High speed is ignored in
  // synchronous mode. Sixteen-bit high speed divides by four.
  always_comb begin
    if (cfg.syncMode) begin
      preLast = sbrg_pkg::PRE_LAST_4;
    end else begin
      unique case ({cfg.sixteenBit, cfg.highSpeed})
        2'h0: preLast = sbrg_pkg::PRE_LAST_64;
        2'h1: preLast = sbrg_pkg::PRE_LAST_16;
        2'h2: preLast = sbrg_pkg::PRE_LAST_16;
        2'h3: preLast = sbrg_pkg::PRE_LAST_4;
      endcase
    end
  end

  // Divisor: high byte over low byte in sixteen-bit mode, low byte
  // alone otherwise.
  always_comb begin
    divisor  = cfg.sixteenBit ? {divHi_reg, divLo_reg} : {8'h00, divLo_reg};
    // A mode change can leave the count past the new end; the >=
    // compare wraps it at once instead of running round 64 or 65536.
    preTick  = (pre_reg >= preLast);
    rateTick = preTick && (count_reg >= divisor);
  end

  // Prescaler; cleared by a divisor write so the new rate starts from
  // a whole period.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || divWrite) begin
      pre_reg <= 6'h00;
    end else if (preTick) begin
      pre_reg <= 6'h00;
    end else begin
      pre_reg <= pre_reg + 6'h01;
    end
  end

  // Timer runs n+1 prescaler periods and reloads by itself.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || divWrite) begin
      count_reg <= 16'h0000;
    end else if (rateTick) begin
      count_reg <= 16'h0000;
    end else if (preTick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  ////////////////////////////////////////////////////////////////////

  logic [1:0] rxSync_reg;  // Receive pin, two flip-flops.
  logic [1:0] ckSync_reg;  // External clock pin, two flip-flops.
  logic       ckPrev_reg;  // Synchronised clock one cycle back.
  logic       extRise;     // Rising edge of the external clock.

  // Both pins pass two flip-flops before any logic reads them; only
  // the second stage feeds the edge detector and the sampler.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rxSync_reg <= 2'h3;
      ckSync_reg <= 2'h0;
      ckPrev_reg <= 1'b0;
    end else begin
      rxSync_reg <= {rxSync_reg[0], receiveDataPin};
      ckSync_reg <= {ckSync_reg[0], extClockPin};
      ckPrev_reg <= ckSync_reg[1];
    end
  end

  always_comb begin
    extRise = ckSync_reg[1] && !ckPrev_reg;
  end

  ////////////////////////////////////////////////////////////////////
  // Bit timing selection.
  ////////////////////////////////////////////////////////////////////

  logic slaveMode;    // Synchronous with external clock.
  logic bitTick_next; // Next value of the bit strobe.

  // In synchronous slave mode the pin clock times the bits and the
  // rate formulas do not apply; otherwise the timer does.
  always_comb begin
    slaveMode    = cfg.syncMode && !cfg.clockSource;
    bitTick_next = slaveMode ? extRise : rateTick;
  end

  // Registered strobe and mode flag, one cycle after their cause.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bitTick           <= 1'b0;
      masterClockActive <= 1'b0;
    end else begin
      bitTick           <= bitTick_next;
      masterClockActive <= cfg.syncMode && cfg.clockSource;
    end
  end

  // Majority vote of the receive pin at each bit strobe.
  sbrg_majority_sampler u_sampler (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .pinLevel   (rxSync_reg[1]),
    .voteEn     (bitTick_next),
    .votedLevel (rxLevel)
  );

  ////////////////////////////////////////////////////////////////////
  // AXI read path.
  ////////////////////////////////////////////////////////////////////

  logic [7:0]  rdOff;  // Word-aligned read offset.
  logic [31:0] rdWord; // Value at that offset.
  logic        rdOk;   // Offset is mapped.

  // Read multiplexer; fixed read-only bits are merged in here.
  always_comb begin
    rdOff  = {araddr[7:2], 2'h0};
    rdWord = 32'h0000_0000;
    rdOk   = 1'b1;
    unique case (rdOff)
      sbrg_pkg::OFF_TXSC: begin
        rdWord[7:0] = txsc_reg | sbrg_pkg::TXSC_ONES;
      end
      sbrg_pkg::OFF_RXSC: begin
        rdWord[7:0] = rxsc_reg;
      end
      sbrg_pkg::OFF_RATE: begin
        rdWord[7:0] = rate_reg | sbrg_pkg::RATE_ONES;
      end
      sbrg_pkg::OFF_DIV_HI: begin
        rdWord[7:0] = divHi_reg;
      end
      sbrg_pkg::OFF_DIV_LO: begin
        rdWord[7:0] = divLo_reg;
      end
      sbrg_pkg::OFF_STATUS: begin
        rdWord[sbrg_pkg::BIT_ST_RXLVL]  = rxLevel;
        rdWord[sbrg_pkg::BIT_ST_MASTER] = masterClockActive;
        rdWord[sbrg_pkg::BIT_ST_COUNT +: 16] = count_reg;
      end
      default: begin
        rdOk = 1'b0; // Unmapped reads return zero with an error.
      end
    endcase
  end

  // Read data is captured on the address handshake and held until the
  // master takes it.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= sbrg_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rdWord;
      rresp  <= rdOk ? sbrg_pkg::RESP_OKAY : sbrg_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // sbrg_rate_gen

// >>> tb/sbrg_monitor.sv
// Purpose: Port assertions for the serial bit-rate generator.
// Assumes: One sys_clk domain with a synchronous active-high reset.
// Notes:   Bound into sbrg_rate_gen; it sees that module's ports only.
`timescale 1ns/1ps
module sbrg_monitor (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        bitTick,
  input wire logic        rxLevel,
  input wire logic        masterClockActive
);
  ////////////////////////////////////////
  // Every check runs on sys_clk and is muted while reset is held.
  default clocking mcb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // The strobe lasts one cycle.
  tick_single_a: assert property (bitTick |=> !bitTick) else $error("strobe too long");
  // The voted level may only move together with a new strobe.
  rx_vote_a: assert property ($changed(rxLevel) |-> $rose(bitTick))
    else $error("voted level moved off strobe");
  // Status reads return the live vote and the master flag.
  stat_bits_a: assert property (arvalid && arready && araddr[7:2] == 6'h05
    |=> rdata[1:0] == {$past(masterClockActive), $past(rxLevel)}) else $error("status bits");
  // Unmapped reads give an error and zero.
  bad_read_a: assert property (arvalid && arready && araddr > 8'h17
    |=> rresp == sbrg_pkg::RESP_SLVERR && rdata == 32'h00000000) else $error("unmapped read");
  // A taken read answers on the next edge.
  read_answer_a: assert property (arvalid && arready |=> rvalid) else $error("read late");
  // A write taken in one go answers two edges later.
  write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write late");
  // Answers stand until the master takes them.
  b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("b drop");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("r drop");
  // No new write is taken while a write answer is pending.
  busy_block_a: assert property (bvalid |-> !awready && !wready && (!rvalid || !arready))
    else $error("ready while busy");

  cover property (bvalid && bready);
  cover property (rvalid && rresp == sbrg_pkg::RESP_SLVERR);
  cover property ($fell(rxLevel));
endmodule // sbrg_monitor

bind sbrg_rate_gen sbrg_monitor mon_u (
  .sys_clk, .sys_rst, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
  .bitTick, .rxLevel, .masterClockActive
);

// >>> tb/sbrg_partner.sv
// Purpose: Serial-side partner: drives the receive line and the slave clock.
// Assumes: Pins change just after an edge.
// Notes:   The slave clock has a period of 40 sys_clk cycles.
`timescale 1ns/1ps
module sbrg_partner (
  input wire logic sys_clk,
  input wire logic lineLevel,
  input wire logic glitchOn,
  input wire logic extRun,
  output logic     receiveDataPin = 1'b1,
  output logic     extClockPin = 1'b0
);
  int phase = 0; // Free cycle counter, 0 to 19.

  ////////////////////////////////////////
  // The slave clock idles low outside a session; a one-cycle glitch every
  // fifth cycle tests the vote.
  always @(posedge sys_clk) begin
    phase <= (phase == 19) ? 0 : phase + 1;
    if (!extRun) begin
      extClockPin <= 1'b0;
    end else if (phase == 19) begin
      extClockPin <= !extClockPin;
    end
    receiveDataPin <= lineLevel ^ (glitchOn && (phase % 5 == 0));
  end
endmodule // sbrg_partner

// >>> tb/test_serial_baud_rate_generator.sv
// Purpose: Self-checking bench for the bit-rate generator over AXI4-Lite.
// Assumes: 50 ns clock; inputs change just after rising edges.
// Notes:   Bus answers are sampled at rising edges, the strobe at falling ones.
`timescale 1ns/1ps
module test_serial_baud_rate_generator;
  localparam int LIM = 20000; // Bound of every wait.
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, bitTick, rxLevel, masterClockActive;
  logic [1:0] bresp, rresp, rr;
  logic [31:0] rdata, d;
  logic receiveDataPin, extClockPin;
  logic lineLevel = 1'b1, glitchOn = 1'b0, extRun = 1'b0;
  int err_total = 0, compares = 0, i, n, bad;
  // Mode table: transmit byte, rate byte, divisor high, divisor low.
  logic [7:0] mTx[6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h94, 8'h90};
  logic [7:0] mRt[6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
  logic [7:0] mHi[6] = '{8'h05, 8'h01, 8'h01, 8'h00, 8'h07, 8'h00};
  logic [7:0] mLo[6] = '{8'h02, 8'h03, 8'h00, 8'h09, 8'h05, 8'h07};
  logic [7:0] rOff[5] = '{sbrg_pkg::OFF_TXSC, sbrg_pkg::OFF_RXSC, sbrg_pkg::OFF_RATE,
                          sbrg_pkg::OFF_DIV_HI, sbrg_pkg::OFF_DIV_LO};

  always #25 sys_clk = ~sys_clk;

  sbrg_rate_gen dut_u (.sys_clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .receiveDataPin, .extClockPin, .bitTick, .rxLevel,
    .masterClockActive);
  sbrg_partner far_u (.sys_clk, .lineLevel, .glitchOn, .extRun, .receiveDataPin,
    .extClockPin);

  ////////////////////////////////////////
  // Verdict and end of run; a timeout ends here too.
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic tmo(input bit ok);
    if (!ok) begin
      err_total++;
      $display("mismatch at %0t: wait ran out", $time);
      test_done();
    end
  endtask

  ////////////////////////////////////////
  // Write: address and data offered together, each dropped when taken.
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                     input logic [1:0] er);
    bit done;
    logic [1:0] r;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    for (int k = 0; k < LIM && !done; k++) begin
      @(posedge sys_clk);
      done = bvalid;
      r = bresp;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    tmo(done);
    chk(r, er, "write response");
  endtask

  // Read: address held until taken, data taken with rvalid.
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    bit done;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    for (int k = 0; k < LIM && !done; k++) begin
      @(posedge sys_clk);
      done = rvalid;
      v = rdata;
      r = rresp;
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    tmo(done);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
    logic [1:0] r;
    axr(a, d, r);
    chk(d, ev, "read data");
    chk(r, er, "read response");
  endtask

  // Mode setup; the low byte goes last so its write restarts the timer.
  task automatic cfg(input logic [7:0] tx, rt, hi, lo);
    axw(sbrg_pkg::OFF_TXSC, {24'h0, tx}, 4'hF, sbrg_pkg::RESP_OKAY);
    axw(sbrg_pkg::OFF_RATE, {24'h0, rt}, 4'hF, sbrg_pkg::RESP_OKAY);
    axw(sbrg_pkg::OFF_DIV_HI, {24'h0, hi}, 4'hF, sbrg_pkg::RESP_OKAY);
    axw(sbrg_pkg::OFF_DIV_LO, {24'h0, lo}, 4'hF, sbrg_pkg::RESP_OKAY);
  endtask

  // Counts falling edges until the strobe is seen, so two calls give the period.
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(negedge sys_clk);
      c++;
    end while (bitTick !== 1'b1 && c < LIM);
    tmo(bitTick === 1'b1);
  endtask

  ////////////////////////////////////////
  // The clock never changes rate, so divisors are set once per mode.
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // Reset values, write masks, unmapped and read-only places.
    rdchk(sbrg_pkg::OFF_TXSC, 32'h02, sbrg_pkg::RESP_OKAY);
    rdchk(sbrg_pkg::OFF_RATE, 32'h40, sbrg_pkg::RESP_OKAY);
    for (i = 0; i < 5; i++) begin
      axw(rOff[i], 32'hFFFFFFFF, 4'hF, sbrg_pkg::RESP_OKAY);
      d = (i == 0) ? 32'hFF : (i == 1) ? 32'hF8 : (i == 2) ? 32'hFB : 32'hFF;
      rdchk(rOff[i], d, sbrg_pkg::RESP_OKAY);
      axw(rOff[i], 32'h00000000, 4'hF, sbrg_pkg::RESP_OKAY);
    end
    axw(sbrg_pkg::OFF_DIV_LO, 32'h33, 4'hE, sbrg_pkg::RESP_OKAY);
    rdchk(sbrg_pkg::OFF_DIV_LO, 32'h00, sbrg_pkg::RESP_OKAY);
    axw(8'h18, 32'h55, 4'hF, sbrg_pkg::RESP_SLVERR);
    axw(sbrg_pkg::OFF_STATUS, 32'h55, 4'hF, sbrg_pkg::RESP_SLVERR);
    rdchk(8'h18, 32'h00, sbrg_pkg::RESP_SLVERR);
    $display("test registers ended, mismatches %0d", err_total);
    // Strobe period in each master mode is R*(n+1).
    for (i = 0; i < 6; i++) begin
      cfg(mTx[i], mRt[i], mHi[i], mLo[i]);
      bad = (mTx[i][4] ? 4 : (!mRt[i][3] && !mTx[i][2]) ? 64 : (mRt[i][3] && mTx[i][2]) ? 4 : 16)
            * ((mRt[i][3] ? {mHi[i], mLo[i]} : {8'h00, mLo[i]}) + 1);
      wait_tick(n);
      wait_tick(n);
      chk(n, bad, "strobe period");
    end
    $display("test modes ended, mismatches %0d", err_total);
    // A divisor write in mid-count restarts the timer at the new rate.
    cfg(8'h00, 8'h00, 8'h00, 8'hFF);
    repeat (3000) @(posedge sys_clk);
    axw(sbrg_pkg::OFF_DIV_LO, 32'h01, 4'hF, sbrg_pkg::RESP_OKAY);
    wait_tick(n);
    chk(n, 128, "restart delay");
    $display("test restart ended, mismatches %0d", err_total);
    // Slave mode follows the external clock; master mode sets the status flag.
    cfg(8'h10, 8'h00, 8'h00, 8'h00);
    extRun <= 1'b1;
    wait_tick(n);
    wait_tick(n);
    chk(n, 40, "slave period");
    chk(masterClockActive, 1'b0, "slave flag");
    extRun <= 1'b0;
    axw(sbrg_pkg::OFF_TXSC, 32'h90, 4'hF, sbrg_pkg::RESP_OKAY);
    rdchk(sbrg_pkg::OFF_TXSC, 32'h92, sbrg_pkg::RESP_OKAY);
    axr(sbrg_pkg::OFF_STATUS, d, rr);
    chk(d[1], 1'b1, "master flag");
    $display("test clock source ended, mismatches %0d", err_total);
    // Single-cycle glitches never win the three-sample vote.
    cfg(8'h04, 8'h00, 8'h00, 8'h00);
    glitchOn <= 1'b1;
    bad = 0;
    repeat (300) begin
      @(negedge sys_clk);
      if (rxLevel !== 1'b1) bad++;
    end
    chk(bad, 0, "glitch on high line");
    lineLevel <= 1'b0;
    repeat (3) wait_tick(n);
    chk(rxLevel, 1'b0, "voted low level");
    axr(sbrg_pkg::OFF_STATUS, d, rr);
    chk(d[0], 1'b0, "status level");
    $display("test sampling ended, mismatches %0d", err_total);
    test_done();
  end
endmodule // test_serial_baud_rate_generator
